// ### inc/tlrb_pkg.sv
// Package of register map, reset values and widths for the threshold bank
// Function
// - Local high threshold, command 05, reset 3C
// - Local low threshold, command 06, reset 00
// - Remote high MSB, command 07, reset 50
// - Remote low MSB, command 08, reset 00
// - One degree Celsius per threshold LSB
// - Thresholds are two's complement signed bytes
// - Write purges matching fault queue
// - Config reset restores unlocked thresholds
package tlrb_pkg;
    // Register width and count
    localparam int TLRB_DATA_W = 8;
    localparam int TLRB_NUM_REGS = 4;
    // Command bytes selecting each threshold
    localparam logic [7:0] TLRB_CMD_LOCAL_HIGH  = 8'h05;
    localparam logic [7:0] TLRB_CMD_LOCAL_LOW   = 8'h06;
    localparam logic [7:0] TLRB_CMD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] TLRB_CMD_REMOTE_LOW  = 8'h08;
    // Power-up values, two's complement degrees
    localparam logic [7:0] TLRB_RST_LOCAL_HIGH  = 8'h3c;
    localparam logic [7:0] TLRB_RST_LOCAL_LOW   = 8'h00;
    localparam logic [7:0] TLRB_RST_REMOTE_HIGH = 8'h50;
    localparam logic [7:0] TLRB_RST_REMOTE_LOW  = 8'h00;
    // Index of each threshold within the bank
    localparam int TLRB_IDX_LOCAL_HIGH  = 0;
    localparam int TLRB_IDX_LOCAL_LOW   = 1;
    localparam int TLRB_IDX_REMOTE_HIGH = 2;
    localparam int TLRB_IDX_REMOTE_LOW  = 3;
    // Default value table, indexed as above
    localparam logic [31:0] TLRB_RST_TABLE =
        {TLRB_RST_REMOTE_LOW, TLRB_RST_REMOTE_HIGH,
         TLRB_RST_LOCAL_LOW, TLRB_RST_LOCAL_HIGH};
endpackage : tlrb_pkg

// ### rtl/tlrb_thresh_reg.sv
// One threshold register with its write and restore logic
`timescale 1ns/1ps
module tlrb_thresh_reg
    import tlrb_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       wr_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic       restore,
    output logic      [7:0] value,
    output logic            purge
);
    // Stored limit; a host write beats a restore in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            value <= RESET_VALUE;
        else if (wr_sel)
            value <= wr_data;
        else if (restore)
            value <= RESET_VALUE;
    end

    // One-cycle purge pulse after each completed write
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            purge <= 1'b0;
        else
            purge <= wr_sel;
    end
endmodule : tlrb_thresh_reg

// ### rtl/tlrb_bank.sv
// Bank of four temperature threshold registers selected by command byte
`timescale 1ns/1ps
module tlrb_bank
    import tlrb_pkg::*;
#(
    // Width of one threshold byte; the ports are fixed at eight bits
    parameter int DATA_W   = TLRB_DATA_W,
    // Number of thresholds; lock and purge ports carry four bits
    parameter int NUM_REGS = TLRB_NUM_REGS
) (
    // Device clock and synchronous reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Host access from the serial engine, same clock
    input  wire logic [7:0] cmd,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    // Config restore request and per-register locks
    input  wire logic       cfg_reset,
    input  wire logic [3:0] reset_lock,
    // Read answer
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic            rd_hit,
    // Limits for the comparators, then purge pulses
    output logic      [7:0] local_high_threshold,
    output logic      [7:0] local_low_threshold,
    output logic      [7:0] remote_high_threshold_msb,
    output logic      [7:0] remote_low_threshold_msb,
    output logic      [3:0] fault_queue_purge
);
    // Sizes the logic below can serve; anything else is refused
    generate
        if (DATA_W != 8)
        begin : g_bad_data_w
            $error("tlrb_bank needs DATA_W of 8");
        end
        if (NUM_REGS != 4)
        begin : g_bad_num_regs
            $error("tlrb_bank needs NUM_REGS of 4");
        end
    endgenerate

    // Timing seen at the ports, counted in ref_clk edges:
    //   edge 0: wr_en or rd_en sampled high together with cmd
    //   edge 1: stored value updated, read answer shown
    //   edge 2: exported threshold and purge pulse shown
    // The extra stage on the exports keeps every output on a flop,
    // at the cost of one cycle of lag for the comparators.
    // A write and a config restore in one cycle: the write wins,
    // and the lock bits never block a host write.
    // Back-to-back strobes are fine; nothing here needs a gap.

    // Limitation: only the high byte of each remote limit lives here;
    // the remote low-byte limits sit in another bank.
    // Limitation: cmd must be steady at the strobe edge; it is not
    // synchronised, as it comes from the serial engine on this clock.

    // Decoded selects and stored values
    logic [NUM_REGS-1:0] sel;              // One-hot command decode
    logic [DATA_W-1:0]   vals [NUM_REGS];  // Stored thresholds
    logic [NUM_REGS-1:0] purge;            // Purge pulses per threshold
    logic [DATA_W-1:0]   next_rd_data;     // Read mux result
    logic                next_rd_hit;      // Command is mapped
    logic [NUM_REGS-1:0] restore;          // Unlocked restore requests

    // Command decode; one select at most, none when unmapped.
    // Plain equality, so commands 00..04 and 09..FF hit nothing
    // and a stray write there changes no state.
    always_comb
    begin
        sel = '0;
        sel[TLRB_IDX_LOCAL_HIGH]  = (cmd == TLRB_CMD_LOCAL_HIGH);
        sel[TLRB_IDX_LOCAL_LOW]   = (cmd == TLRB_CMD_LOCAL_LOW);
        sel[TLRB_IDX_REMOTE_HIGH] = (cmd == TLRB_CMD_REMOTE_HIGH);
        sel[TLRB_IDX_REMOTE_LOW]  = (cmd == TLRB_CMD_REMOTE_LOW);
    end

    // Config restore per register, held off by its lock bit.
    // Locks are applied here so the register module stays unaware
    // of how the locks are arranged.
    always_comb
    begin
        restore = {NUM_REGS{cfg_reset}} & ~reset_lock;
    end

    // One register per threshold; each takes its own power-up value
    // from the package table, low byte for the local high limit.
    // A write pulses that register's purge line the next cycle so
    // the matching fault queue restarts from empty.
    // Bit order of sel, restore and purge matches the lock port.
    genvar gi;
    generate
        for (gi = 0; gi < TLRB_NUM_REGS; gi++)
        begin : g_reg
            tlrb_thresh_reg #(
                .RESET_VALUE (TLRB_RST_TABLE[gi*8 +: 8])
            ) u_reg (
                .ref_clk (ref_clk),
                .rst     (rst),
                .wr_sel  (wr_en && sel[gi]),
                .wr_data (wr_data),
                .restore (restore[gi]),
                .value   (vals[gi]),
                .purge   (purge[gi])
            );
        end
    endgenerate

    // Read mux; unmapped commands read zero, no state touched.
    // Reads are pure: nothing here feeds back into a register, so a
    // read may sit beside a write; it sees the value before the write.
    // Zero for unmapped commands keeps the answer free of stale data.
    always_comb
    begin
        next_rd_data = 8'h00;
        next_rd_hit  = 1'b0;
        case (cmd)
            TLRB_CMD_LOCAL_HIGH:
            begin
                next_rd_data = vals[TLRB_IDX_LOCAL_HIGH];
                next_rd_hit  = 1'b1;
            end
            TLRB_CMD_LOCAL_LOW:
            begin
                next_rd_data = vals[TLRB_IDX_LOCAL_LOW];
                next_rd_hit  = 1'b1;
            end
            TLRB_CMD_REMOTE_HIGH:
            begin
                next_rd_data = vals[TLRB_IDX_REMOTE_HIGH];
                next_rd_hit  = 1'b1;
            end
            TLRB_CMD_REMOTE_LOW:
            begin
                next_rd_data = vals[TLRB_IDX_REMOTE_LOW];
                next_rd_hit  = 1'b1;
            end
            default:
            begin
                next_rd_data = 8'h00;
                next_rd_hit  = 1'b0;
            end
        endcase
    end

    // Registered read answer, one cycle after rd_en.
    // rd_data holds between reads so a slow host may pick it up late;
    // rd_valid and rd_hit are single-cycle pulses.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // Quiet answer port out of reset
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            rd_hit   <= 1'b0;
        end
        else
        begin
            // Pulses follow the strobe by one edge
            rd_valid <= rd_en;
            rd_hit   <= rd_en && next_rd_hit;
            // Answer captured only on a read; held otherwise
            if (rd_en)
                rd_data <= next_rd_data;
        end
    end

    // Thresholds exported for the comparators, signed degrees.
    // Each byte is two's complement, one degree per count.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // Power-up limits, in step with the stored ones
            local_high_threshold      <= TLRB_RST_LOCAL_HIGH;
            local_low_threshold       <= TLRB_RST_LOCAL_LOW;
            remote_high_threshold_msb <= TLRB_RST_REMOTE_HIGH;
            remote_low_threshold_msb  <= TLRB_RST_REMOTE_LOW;
        end
        else
        begin
            // Copies lag the stored value by one cycle
            local_high_threshold      <=
                vals[TLRB_IDX_LOCAL_HIGH];
            local_low_threshold       <=
                vals[TLRB_IDX_LOCAL_LOW];
            remote_high_threshold_msb <=
                vals[TLRB_IDX_REMOTE_HIGH];
            remote_low_threshold_msb  <=
                vals[TLRB_IDX_REMOTE_LOW];
        end
    end

    // Fault queue purge pulses, one cycle each, same order as locks.
    // A config restore does not purge here; the config logic owns
    // that purge, which keeps this bank free of config decoding.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // No purge pending out of reset
            fault_queue_purge <= 4'h0;
        end
        else
        begin
            // Follows the register pulses, aligned with the exports
            fault_queue_purge <= purge;
        end
    end
endmodule : tlrb_bank

// ### tb/tlrb_bank_chk.sv
// Port assertions for the threshold bank
`timescale 1ns/1ps
module tlrb_bank_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [7:0] cmd,
    input wire logic       wr_en,
    input wire logic [7:0] wr_data,
    input wire logic       rd_en,
    input wire logic       cfg_reset,
    input wire logic [3:0] reset_lock,
    input wire logic       rd_valid,
    input wire logic       rd_hit,
    input wire logic [7:0] local_high_threshold,
    input wire logic [3:0] fault_queue_purge
);
    // Command lies in the mapped window
    wire mapped = cmd inside {[8'h05:8'h08]};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wr_purge_a: assert property (wr_en && cmd == 8'h05 |-> ##2
        fault_queue_purge[0]) else $error("purge missing");
    stray_purge_a: assert property (!(wr_en && mapped) |-> ##2
        fault_queue_purge == 4'h0) else $error("stray purge");
    wr_value_a: assert property (wr_en && cmd == 8'h05 |-> ##2
        local_high_threshold == $past(wr_data, 2)) else $error("bad store");
    rd_valid_a: assert property (rd_en |=> rd_valid)
        else $error("no valid");
    rd_hit_a: assert property (rd_en |=> rd_hit == $past(mapped))
        else $error("bad hit");
    // Reset gating off here: the check looks at the release itself
    boot_dflt_a: assert property (
        disable iff (1'b0) $fell(rst) |->
        local_high_threshold == 8'h3c) else $error("bad boot value");
    cfg_dflt_a: assert property (
        cfg_reset && !reset_lock[0] && !wr_en
        |-> ##2 local_high_threshold == 8'h3c) else $error("no restore");
    lock_hold_a: assert property (
        cfg_reset && reset_lock[0] && !wr_en
        |-> ##2 $stable(local_high_threshold)) else $error("lock ignored");
endmodule : tlrb_bank_chk
bind tlrb_bank tlrb_bank_chk u_chk (.*);

// ### tb/tlrb_host.sv
// Host model issuing command-byte register accesses
`timescale 1ns/1ps
module tlrb_host (
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_hit,
    output logic      [7:0] cmd,
    output logic            wr_en,
    output logic      [7:0] wr_data,
    output logic            rd_en
);
    // Quiet bus, no strobes
    initial {cmd, wr_en, wr_data, rd_en} = 18'h0_0000;
    // One-cycle strobe; data line shows the inverse once released
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(posedge ref_clk) #1;
        {cmd, wr_en, wr_data} = {c, 1'b1, d};
        @(posedge ref_clk) #1;
        {wr_en, wr_data} = {1'b0, ~d};
    endtask : wr
    // Answer taken with the valid pulse one edge on
    task automatic rd(input logic [7:0] c, output logic [8:0] q);
        @(posedge ref_clk) #1;
        {cmd, rd_en} = {c, 1'b1};
        @(posedge ref_clk) #1;
        rd_en = 1'b0;
        q = {rd_hit, rd_data};
    endtask : rd
endmodule : tlrb_host

// ### tb/tlrb_bank_test.sv
// Directed bench for the threshold bank
`timescale 1ns/1ps
module tlrb_bank_test import tlrb_pkg::*;;
    logic ref_clk = 0, rst = 1, cfg_reset = 0, wr_en, rd_en, rd_valid, rd_hit;
    logic [3:0] reset_lock = 4'h0, fault_queue_purge;
    logic [7:0] cmd, wr_data, rd_data, local_high_threshold, local_low_threshold;
    logic [7:0] remote_high_threshold_msb, remote_low_threshold_msb;
    logic [8:0] q;
    logic [31:0] exp = TLRB_RST_TABLE;
    int num_errors = 0, compares = 0;
    // All four thresholds, local high in the low byte
    wire [31:0] seen = {remote_low_threshold_msb, remote_high_threshold_msb,
        local_low_threshold, local_high_threshold};
    always #50 ref_clk = ~ref_clk;
    tlrb_bank u_dut (.*);
    tlrb_host u_host (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want)
        begin
            num_errors++;
            $display("unexpected at %0t: %h not %h", $time, got, want);
        end
    endtask : chk
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // Restore pulse, then wait until outputs show it
    task automatic restore(input logic [3:0] lk);
        @(posedge ref_clk) #1;
        {cfg_reset, reset_lock} = {1'b1, lk};
        @(posedge ref_clk) #1;
        cfg_reset = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : restore
    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk(seen, exp);
        // Defaults, then negative values written and read back
        for (int i = 0; i < 4; i++)
        begin
            u_host.rd(8'h05 + 8'(i), q);
            chk(q, {1'b1, exp[8*i+:8]});
            chk(rd_valid, 1'b1);
            exp[8*i+:8] = 8'hd8 + 8'(i);
            u_host.wr(8'h05 + 8'(i), exp[8*i+:8]);
            u_host.rd(8'h05 + 8'(i), q);
            chk(q, {1'b1, exp[8*i+:8]});
        end
        // Unmapped command touches nothing
        u_host.wr(8'h09, 8'h7f);
        u_host.rd(8'h04, q);
        chk(q, 9'h000);
        chk(seen, exp);
        restore(4'h5);
        exp = {8'h00, exp[23:16], 8'h00, exp[7:0]};
        chk(seen, exp);
        restore(4'h0);
        chk(seen, TLRB_RST_TABLE);
        wrap_up();
    end
    // Hang guard, far beyond the few microseconds the tests need
    initial
    begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule : tlrb_bank_test
